// File: rtl/ldcr_config_regs.sv
// I2C target and field decoders of the LED driver configuration bank.
// Assumes SCL and SDA arrive asynchronously on pins; SDA is open drain.
`timescale 1ns/1ns
`default_nettype none

module ldcr_config_regs #(
  parameter logic [1:0] MAKER_ID = ldcr_pkg::MAKER_ID_DEFAULT // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Decoded backlight settings
  output logic [5:0] ovp_volts,
  output logic curve_linear,
  output logic pwm_active_low,
  output logic switch_1mhz,
  output logic eleven_bit_brightness_enable,
  output logic [10:0] brightness_code,
  // Decoded flash settings
  output logic [8:0] torch_current_ma,
  output logic [10:0] strobe_current_ma
);

  // ****************************************
  // Checks and shared functions
  // ****************************************
  // Pin filter must settle well inside one fast-mode bit
  if (ldcr_pkg::BIT_CYCLES < 4 * ldcr_pkg::SYNC_LATENCY) begin : g_rate_chk
    $error("Clock too slow for fast-mode I2C");
  end

  // Saturating current code, used by torch and strobe alike
  function automatic logic [3:0] sat_code(input logic [3:0] code);
    sat_code = (code > ldcr_pkg::CUR_CODE_MAX) ? ldcr_pkg::CUR_CODE_MAX : code;
  endfunction : sat_code

  // Overvoltage code to volts; 5 to 7 all give the top level
  function automatic logic [5:0] ovp_of(input logic [2:0] code);
    case (code)
      3'h0: ovp_of = 6'h12;
      3'h1: ovp_of = 6'h16;
      3'h2: ovp_of = 6'h19;
      3'h3: ovp_of = 6'h1D;
      3'h4: ovp_of = 6'h21;
      default: ovp_of = 6'h24;
    endcase
  endfunction : ovp_of

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] scl_sync; // Three-stage pin filter
  logic [2:0] sda_sync;
  logic scl_s; // Filtered levels
  logic sda_s;
  logic next_scl_s;
  logic next_sda_s;

  // A level only counts once the last two stages agree
  always_comb begin
    next_scl_s = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_s;
    next_sda_s = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_s;
  end

  // Register the filter; idle bus is high
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      scl_s <= next_scl_s;
      sda_s <= next_sda_s;
    end
  end

  // Bus events seen on the filtered levels
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = next_scl_s && !scl_s;
  assign scl_fall = !next_scl_s && scl_s;
  assign start_ev = scl_s && next_scl_s && sda_s && !next_sda_s;
  assign stop_ev = scl_s && next_scl_s && !sda_s && next_sda_s;

  // ****************************************
  // Transfer state machine
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_REG = 4'h3,
    ST_ACK_REG = 4'h4,
    ST_WR = 4'h5,
    ST_ACK_WR = 4'h6,
    ST_RD = 4'h7,
    ST_RD_ACK = 4'h8
  } ldcr_state_t;

  ldcr_state_t state;
  ldcr_state_t next_state;
  logic [3:0] bit_cnt; // Bits seen in this byte
  logic [3:0] next_bit_cnt;
  logic [7:0] shift; // Incoming byte
  logic [7:0] next_shift;
  logic [7:0] tx; // Outgoing byte
  logic [7:0] next_tx;
  logic [7:0] ptr; // Register pointer, auto-increments
  logic [7:0] next_ptr;
  logic rw; // Read when set
  logic next_rw;
  logic pull; // Drive SDA low
  logic next_pull;
  logic host_nack; // Host declined more read data
  logic next_host_nack;
  logic wr_en;
  logic next_wr_en;

  ldcr_reg_if rif ();

  // Data moves on SCL rise, SDA changes only after SCL falls
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    next_tx = tx;
    next_ptr = ptr;
    next_rw = rw;
    next_pull = pull;
    next_host_nack = host_nack;
    next_wr_en = 1'b0;
    if (start_ev) begin
      // Repeated start is taken from any state
      next_state = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_pull = 1'b0;
    end else if (stop_ev) begin
      next_state = ST_IDLE;
      next_pull = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          next_pull = 1'b0;
        end
        ST_ADDR, ST_REG, ST_WR: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_pull = 1'b1;
            if (state == ST_ADDR) begin
              // Foreign addresses get no acknowledge
              if (shift[7:1] == ldcr_pkg::TARGET_ADDR) begin
                next_state = ST_ACK_ADDR;
                next_rw = shift[0];
              end else begin
                next_state = ST_IDLE;
                next_pull = 1'b0;
              end
            end else if (state == ST_REG) begin
              next_state = ST_ACK_REG;
              next_ptr = shift;
            end else begin
              next_state = ST_ACK_WR;
              next_wr_en = 1'b1;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_REG, ST_ACK_WR: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (state == ST_ACK_WR) begin
              next_ptr = ptr + 8'h01;
            end
            if (state == ST_ACK_ADDR && rw) begin
              // First read byte goes out on this fall
              next_state = ST_RD;
              next_tx = rif.rdata;
              next_pull = !rif.rdata[7];
              next_ptr = ptr + 8'h01;
            end else begin
              next_state = (state == ST_ACK_ADDR) ? ST_REG : ST_WR;
              next_pull = 1'b0;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              // Let go so the host can answer
              next_state = ST_RD_ACK;
              next_pull = 1'b0;
            end else begin
              next_tx = {tx[6:0], 1'b0};
              next_pull = !tx[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            next_host_nack = sda_s;
          end else if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (host_nack) begin
              next_state = ST_IDLE;
              next_pull = 1'b0;
            end else begin
              next_state = ST_RD;
              next_tx = rif.rdata;
              next_pull = !rif.rdata[7];
              next_ptr = ptr + 8'h01;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_pull = 1'b0;
        end
      endcase
    end
  end

  // Register the transfer state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      pull <= 1'b0;
      host_nack <= 1'b0;
      wr_en <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      tx <= next_tx;
      ptr <= next_ptr;
      rw <= next_rw;
      pull <= next_pull;
      host_nack <= next_host_nack;
      wr_en <= next_wr_en;
    end
  end

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = pull;

  // ****************************************
  // Register storage
  // ****************************************
  assign rif.wr_en = wr_en;
  assign rif.addr = ptr;
  assign rif.wdata = shift;

  ldcr_reg_file #(
    .MAKER_ID(MAKER_ID)
  ) u_reg_file (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .rif(rif)
  );

  // ****************************************
  // Field decoders
  // ****************************************
  logic [5:0] next_ovp_volts;
  logic next_curve_linear;
  logic next_pwm_active_low;
  logic next_switch_1mhz;
  logic next_eleven;
  logic [10:0] next_brightness;
  logic [8:0] next_torch;
  logic [10:0] next_strobe;

  // Turn stored bytes into settings the analog side can use
  always_comb begin
    next_ovp_volts = ovp_of(rif.cfg_prot[ldcr_pkg::OVP_MSB:ldcr_pkg::OVP_LSB]);
    next_curve_linear = rif.cfg_prot[ldcr_pkg::CURVE_BIT];
    next_pwm_active_low = rif.cfg_prot[ldcr_pkg::PWM_POL_BIT];
    next_switch_1mhz = rif.cfg_swramp[ldcr_pkg::SW_RATE_BIT];
    next_eleven = rif.cfg_swramp[ldcr_pkg::ELEVEN_BIT];
    if (next_eleven) begin
      next_brightness = {rif.cfg_bhi[ldcr_pkg::EXTRA_BIT:0], rif.cfg_blo};
    end else begin
      next_brightness = {1'b0, rif.cfg_bhi[1:0], rif.cfg_blo};
    end
    next_torch = 9'(({5'h00,
      sat_code(rif.cfg_flash[ldcr_pkg::TORCH_MSB:ldcr_pkg::TORCH_LSB])} + 9'h001)
      * ldcr_pkg::TORCH_STEP_MA);
    next_strobe = 11'(({7'h00,
      sat_code(rif.cfg_flash[ldcr_pkg::STROBE_MSB:ldcr_pkg::STROBE_LSB])} + 11'h001)
      * ldcr_pkg::STROBE_STEP_MA);
  end

  // Settings come from flops one cycle after the byte lands
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ovp_volts <= 6'h16;
      curve_linear <= 1'b1;
      pwm_active_low <= 1'b0;
      switch_1mhz <= 1'b0;
      eleven_bit_brightness_enable <= 1'b1;
      brightness_code <= 11'h7FF;
      torch_current_ma <= 9'h064;
      strobe_current_ma <= 11'h5DC;
    end else begin
      ovp_volts <= next_ovp_volts;
      curve_linear <= next_curve_linear;
      pwm_active_low <= next_pwm_active_low;
      switch_1mhz <= next_switch_1mhz;
      eleven_bit_brightness_enable <= next_eleven;
      brightness_code <= next_brightness;
      torch_current_ma <= next_torch;
      strobe_current_ma <= next_strobe;
    end
  end
endmodule : ldcr_config_regs
`default_nettype wire

// File: shared/ldcr_pkg.sv
// Constants shared by the LED driver configuration register bank.
// Assumes one 100 MHz system clock and an I2C target in front.
package ldcr_pkg;

  // ****************************************
  // Bus identity and timing
  // ****************************************
  localparam logic [6:0] TARGET_ADDR = 7'h11; // Target address 0010001
  localparam int FAST_MODE_KBPS = 400; // Highest host bit rate
  localparam int CLK_MHZ = 100; // System clock rate
  // Cycles in one fast-mode bit, rounded down
  localparam int BIT_CYCLES = (CLK_MHZ * 1000) / FAST_MODE_KBPS;
  localparam int SYNC_LATENCY = 3; // Pin filter depth in cycles

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFF_MAKER_ID = 8'h01;
  localparam logic [7:0] OFF_BL_PROT = 8'h02;
  localparam logic [7:0] OFF_BL_SWRAMP = 8'h03;
  localparam logic [7:0] OFF_BRIGHT_HI = 8'h04;
  localparam logic [7:0] OFF_BRIGHT_LO = 8'h05;
  localparam logic [7:0] OFF_FLASH_CUR = 8'h06;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_BL_PROT = 8'h30;
  localparam logic [7:0] RST_BL_SWRAMP = 8'h19;
  localparam logic [7:0] RST_BRIGHT_HI = 8'h07;
  localparam logic [7:0] RST_BRIGHT_LO = 8'hFF;
  localparam logic [7:0] RST_FLASH_CUR = 8'h3E;
  localparam logic [1:0] MAKER_ID_DEFAULT = 2'h1; // Arbitrary value

  // ****************************************
  // Field positions
  // ****************************************
  localparam int OVP_MSB = 7;
  localparam int OVP_LSB = 5;
  localparam int CURVE_BIT = 4;
  localparam int PWM_POL_BIT = 3;
  localparam int SW_RATE_BIT = 7;
  localparam int ELEVEN_BIT = 0;
  localparam int EXTRA_BIT = 2;
  localparam int TORCH_MSB = 7;
  localparam int TORCH_LSB = 4;
  localparam int STROBE_MSB = 3;
  localparam int STROBE_LSB = 0;

  // ****************************************
  // Field encodings
  // ****************************************
  localparam logic [3:0] CUR_CODE_MAX = 4'hE; // Codes above saturate
  localparam logic [8:0] TORCH_STEP_MA = 9'h019; // 25 mA per step
  localparam logic [10:0] STROBE_STEP_MA = 11'h064; // 100 mA per step
endpackage : ldcr_pkg

// File: shared/ldcr_reg_if.sv
// Carrier between the I2C front end and the register storage.
// Assumes both ends sit on clk_sys.
`timescale 1ns/1ns
`default_nettype none
interface ldcr_reg_if;
  logic wr_en; // One-cycle write strobe
  logic [7:0] addr; // Register offset for read and write
  logic [7:0] wdata; // Write data
  logic [7:0] rdata; // Read data at addr
  logic [7:0] cfg_prot; // Live protection and curve byte
  logic [7:0] cfg_swramp; // Live switching and mode byte
  logic [7:0] cfg_bhi; // Live brightness high byte
  logic [7:0] cfg_blo; // Live brightness low byte
  logic [7:0] cfg_flash; // Live flash current byte

  modport front (output wr_en, addr, wdata,
    input rdata, cfg_prot, cfg_swramp, cfg_bhi, cfg_blo, cfg_flash);
  modport store (input wr_en, addr, wdata,
    output rdata, cfg_prot, cfg_swramp, cfg_bhi, cfg_blo, cfg_flash);
endinterface : ldcr_reg_if
`default_nettype wire

// File: rtl/ldcr_reg_file.sv
// Storage for the five writable configuration registers, plus the constant identity byte.
// Assumes writes arrive as single-cycle strobes from the I2C front end.
`timescale 1ns/1ns
`default_nettype none
module ldcr_reg_file #(
  parameter logic [1:0] MAKER_ID = ldcr_pkg::MAKER_ID_DEFAULT // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register access
  ldcr_reg_if.store rif
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] regs [2:6]; // Writable bytes, indexed by offset
  logic [7:0] next_regs [2:6];

  // Reset value of each writable register
  function automatic logic [7:0] reset_of(input int idx);
    case (idx)
      2: reset_of = ldcr_pkg::RST_BL_PROT;
      3: reset_of = ldcr_pkg::RST_BL_SWRAMP;
      4: reset_of = ldcr_pkg::RST_BRIGHT_HI;
      5: reset_of = ldcr_pkg::RST_BRIGHT_LO;
      default: reset_of = ldcr_pkg::RST_FLASH_CUR;
    endcase
  endfunction : reset_of

  // Whole bytes are kept, reserved bits too, so reads give back writes
  always_comb begin
    for (int i = 2; i <= 6; i++) begin
      next_regs[i] = regs[i];
      if (rif.wr_en && rif.addr == 8'(i)) begin
        next_regs[i] = rif.wdata;
      end
    end
  end

  // Register the bytes
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 2; i <= 6; i++) begin
        regs[i] <= reset_of(i);
      end
    end else begin
      for (int i = 2; i <= 6; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // Identity byte is constant, so writes to it simply have no target
  always_comb begin
    unique case (rif.addr)
      ldcr_pkg::OFF_MAKER_ID: rif.rdata = {6'h00, MAKER_ID};
      ldcr_pkg::OFF_BL_PROT, ldcr_pkg::OFF_BL_SWRAMP, ldcr_pkg::OFF_BRIGHT_HI,
      ldcr_pkg::OFF_BRIGHT_LO, ldcr_pkg::OFF_FLASH_CUR: begin
        rif.rdata = regs[rif.addr[2:0]];
      end
      default: rif.rdata = 8'h00; // Unmapped offsets read zero
    endcase
  end

  // Live copies for the decoders
  assign rif.cfg_prot = regs[2];
  assign rif.cfg_swramp = regs[3];
  assign rif.cfg_bhi = regs[4];
  assign rif.cfg_blo = regs[5];
  assign rif.cfg_flash = regs[6];
endmodule : ldcr_reg_file
`default_nettype wire

// File: bench/ldcr_i2c_host.sv
// I2C host model that drives the configuration bank at fast-mode rate.
// Assumes the bench resolves SDA as open drain with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module ldcr_i2c_host (
  // Clock
  input wire logic clk_sys,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // ****************************************
  // Bit timing
  // ****************************************
  // Half of a 250-cycle bit, so the host never beats 400kb/s
  localparam int HALF = 125;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Wait whole clocks so every change lands on a rising edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wt
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    sda_low <= 1'b0;
    wt(62);
    scl <= 1'b1;
    wt(62);
    sda_low <= 1'b1;
    wt(62);
    scl <= 1'b0;
    wt(63);
  endtask : start
  // Stop: SDA rises while SCL is high, then the bus idles released
  task automatic stop();
    sda_low <= 1'b1;
    wt(62);
    scl <= 1'b1;
    wt(62);
    sda_low <= 1'b0;
    wt(HALF);
  endtask : stop
  // One bit; data held past the fall so the target's filter sees it
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    wt(62);
    scl <= 1'b1;
    wt(60);
    r = sda;
    wt(65);
    scl <= 1'b0;
    wt(63);
  endtask : bit_io
  // Byte MSB first, then the acknowledge bit
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(ack_in, ack);
  endtask : xfer
endmodule : ldcr_i2c_host
`default_nettype wire

// File: bench/ldcr_config_regs_sva.sv
// Assertions on the pins and decoded outputs of the configuration bank.
// Assumes one clock, clk_sys, and reset_n active low.
`timescale 1ns/1ns
`default_nettype none
module ldcr_config_regs_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Decoded settings
  input wire logic [5:0] ovp_volts,
  input wire logic curve_linear,
  input wire logic pwm_active_low,
  input wire logic switch_1mhz,
  input wire logic eleven_bit_brightness_enable,
  input wire logic [10:0] brightness_code,
  input wire logic [8:0] torch_current_ma,
  input wire logic [10:0] strobe_current_ma
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // ****************************************
  // Properties
  // ****************************************
  property p_ovp_set;
    ovp_volts inside {6'h12, 6'h16, 6'h19, 6'h1D, 6'h21, 6'h24};
  endproperty
  a_ovp_set: assert property (p_ovp_set) else $error("ovp off table");
  property p_torch_set;
    torch_current_ma % 9'h019 == 9'h0 && torch_current_ma inside {[9'h019:9'h177]};
  endproperty
  a_torch_set: assert property (p_torch_set) else $error("torch off grid");
  property p_strobe_set;
    strobe_current_ma % 11'h064 == 11'h0 && strobe_current_ma inside {[11'h064:11'h5DC]};
  endproperty
  a_strobe_set: assert property (p_strobe_set) else $error("strobe off grid");
  property p_ten_top;
    !eleven_bit_brightness_enable |-> brightness_code[10] == 1'b0;
  endproperty
  a_ten_top: assert property (p_ten_top) else $error("ten-bit top set");
  property p_reset_vals;
    $rose(reset_n) |-> eleven_bit_brightness_enable && brightness_code == 11'h7FF
      && ovp_volts == 6'h16 && curve_linear && !switch_1mhz && !pwm_active_low;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
  // Settings only move after a written byte, which ends with SCL low
  property p_cfg_low;
    $changed({ovp_volts, curve_linear, pwm_active_low, switch_1mhz,
      brightness_code, torch_current_ma, strobe_current_ma}) |-> !scl_in;
  endproperty
  a_cfg_low: assert property (p_cfg_low) else $error("setting moved, scl high");
  property p_oe_move;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_oe_move: assert property (p_oe_move) else $error("sda drive moved, scl high");
  property p_oe_hold;
    $rose(sda_oe) |=> sda_oe [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("sda drive too short");
  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
  c_ack: cover property ($rose(sda_oe));
  c_ten: cover property (!eleven_bit_brightness_enable);
  c_sat: cover property (torch_current_ma == 9'h177);
endmodule : ldcr_config_regs_sva
bind ldcr_config_regs ldcr_config_regs_sva u_sva (.clk_sys, .reset_n, .scl_in, .sda_in,
  .sda_out, .sda_oe, .ovp_volts, .curve_linear, .pwm_active_low, .switch_1mhz,
  .eleven_bit_brightness_enable, .brightness_code, .torch_current_ma, .strobe_current_ma);
`default_nettype wire

// File: bench/ldcr_config_regs_tb_top.sv
// Self-checking bench: register traffic over I2C, decoded outputs compared.
// Assumes the host model and the bound checker compile alongside.
`timescale 1ns/1ns
`default_nettype none
module ldcr_config_regs_tb_top;
  localparam logic [1:0] MAKER = 2'h3; // Arbitrary value
  logic clk_sys, reset_n, scl_in, sda_in, host_low, sda_out, sda_oe;
  logic curve_linear, pwm_active_low, switch_1mhz, eleven_bit_brightness_enable;
  logic [5:0] ovp_volts;
  logic [10:0] brightness_code, strobe_current_ma;
  logic [8:0] torch_current_ma;
  int n_mismatch = 0;
  int compares = 0;
  // Volts for each threshold code
  logic [5:0] ovp_tab [8] = '{6'h12, 6'h16, 6'h19, 6'h1D, 6'h21, 6'h24, 6'h24, 6'h24};
  // Open drain with pull-up: low if either party pulls
  assign sda_in = !(sda_oe && !sda_out) && !host_low;
  ldcr_config_regs #(.MAKER_ID(MAKER)) u_ldcr_config_regs (.clk_sys, .reset_n, .scl_in,
    .sda_in, .sda_out, .sda_oe, .ovp_volts, .curve_linear, .pwm_active_low, .switch_1mhz,
    .eleven_bit_brightness_enable, .brightness_code, .torch_current_ma, .strobe_current_ma);
  ldcr_i2c_host u_host (.clk_sys, .sda(sda_in), .scl(scl_in), .sda_low(host_low));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = !clk_sys;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Write n bytes from the top of d, starting at offset a
  task automatic wr(input logic [7:0] a, input logic [47:0] d, input int n);
    logic [7:0] rx;
    logic ack;
    u_host.start();
    u_host.xfer(8'h22, 1'b1, rx, ack);
    chk("address ack", 1'b0, ack);
    u_host.xfer(a, 1'b1, rx, ack);
    for (int i = 0; i < n; i++) begin
      u_host.xfer(d[47-8*i -: 8], 1'b1, rx, ack);
      chk("data ack", 1'b0, ack);
    end
    u_host.stop();
  endtask : wr
  // Read n bytes from offset a, or from the current pointer when set_ptr is clear;
  // the last byte is refused by the host
  task automatic rd(input logic [7:0] a, input logic [47:0] e, input int n,
                    input bit set_ptr);
    logic [7:0] rx;
    logic ack;
    if (set_ptr) begin
      u_host.start();
      u_host.xfer(8'h22, 1'b1, rx, ack);
      u_host.xfer(a, 1'b1, rx, ack);
    end
    u_host.start();
    u_host.xfer(8'h23, 1'b1, rx, ack);
    chk("read ack", 1'b0, ack);
    for (int i = 0; i < n; i++) begin
      u_host.xfer(8'hFF, i == n - 1, rx, ack);
      chk("read byte", e[47-8*i -: 8], rx);
    end
    u_host.stop();
  endtask : rd
  // Register bytes 0x02..0x06 against every decoded output
  task automatic outs(input logic [39:0] r);
    logic [3:0] t, s;
    // Codes 1110 and 1111 both give the top current
    t = r[7:4] > 4'hE ? 4'hE : r[7:4];
    s = r[3:0] > 4'hE ? 4'hE : r[3:0];
    chk("ovp", ovp_tab[r[39:37]], ovp_volts);
    chk("curve", r[36], curve_linear);
    chk("pwm", r[35], pwm_active_low);
    chk("rate", r[31], switch_1mhz);
    chk("eleven", r[24], eleven_bit_brightness_enable);
    chk("bright", r[24] ? {r[18:8]} : {1'b0, r[17:8]}, brightness_code);
    chk("torch", ({7'h0, t} + 11'h1) * 11'h019, torch_current_ma);
    chk("strobe", ({7'h0, s} + 11'h1) * 11'h064, strobe_current_ma);
  endtask : outs
  task automatic test_done();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    logic [7:0] rx;
    logic ack;
    logic [7:0] ovp_w [4];
    ovp_w = '{8'h70, 8'h98, 8'hB0, 8'hE0};
    reset_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    outs(40'h301907FF3E);
    rd(8'h01, {6'h0, MAKER, 40'h301907FF3E}, 6, 1'b1);
    // Identity byte ignored, then a burst lands in 0x02..0x06
    wr(8'h01, 48'hFF0080065AEF, 6);
    outs(40'h0080065AEF);
    // Foreign address gets no acknowledge and changes nothing
    u_host.start();
    u_host.xfer(8'h24, 1'b1, rx, ack);
    chk("foreign ack", 1'b1, ack);
    u_host.stop();
    outs(40'h0080065AEF);
    wr(8'h02, 48'h4807FD000D00, 5);
    outs(40'h4807FD000D);
    // Threshold codes not yet seen; 110 shares 36 V with 101 and 111 and
    // is left out, since every single-byte write costs about 7k cycles
    foreach (ovp_w[i]) begin
      wr(8'h02, {ovp_w[i], 40'h0}, 1);
      outs({ovp_w[i], 32'h07FD000D});
    end
    // Read on from where the last write left the pointer (0x03)
    rd(8'h00, {32'h07FD000D, 16'h0}, 4, 1'b0);
    test_done();
  end
  // Watchdog: the sequence needs about 99k cycles
  initial begin
    repeat (105000) @(posedge clk_sys);
    n_mismatch++;
    test_done();
  end
endmodule : ldcr_config_regs_tb_top
`default_nettype wire
